// File: core/fld_ctrl.sv
// Control register bank for fast link drop, pair swap and polarity,
// plus the indirect extended register access path.
// Assumes synchronous event strobes from the receive path and an
// extended register space that answers reads in the same cycle.
`timescale 1ns/100ps
`include "fld_regs.svh"

module fld_ctrl (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [`FLD_ADDR_W-1:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_rx_err,
  input wire logic i_mlt3_err,
  input wire logic i_snr_low,
  input wire logic i_energy_lost,
  input wire logic i_dscr_lost,
  input wire logic [15:0] i_ext_rdata,
  output fld_pkg::fld_path_t o_path,
  output logic o_link_drop,
  output fld_pkg::fld_ext_req_t o_ext_req,
  output logic o_ext_stb,
  output logic o_irq
);
  import fld_pkg::*;

  // Bit index of each criterion in the event vector
  localparam int CE = 0;
  localparam int CS = 1;
  localparam int CM = 2;
  localparam int CR = 3;
  localparam int CD = 4;
  localparam logic [10:0] WIN_LAST = 11'(`FLD_WIN_CYC - 1);

  // Software-visible state
  logic [15:0] ctrl3; // Control register three
  logic [15:0] xctl; // Command and target select
  logic [15:0] xptr; // Indirect address pointer
  logic [4:0] drop_stat; // Latched per-criterion drop cause
  logic [4:0] irq_stat; // Sticky interrupt status
  logic [4:0] irq_mask; // Interrupt enables

  // Window and event counters
  logic [10:0] win_cnt; // Cycles into the current window
  logic [5:0] cnt_rx; // Receive errors this window
  logic [5:0] cnt_ml; // Line-code violations this window
  logic [5:0] cnt_sn; // Low-SNR crossings this window

  // Register decode used for both read and write paths
  function automatic logic hit(input logic [`FLD_ADDR_W-1:0] a,
                               input logic [7:0] idx);
    hit = (a[`FLD_ADDR_W-1:2] == idx);
  endfunction

  // Bus handshake: one ack per request, dropped the next cycle
  wire bus_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  wire bus_wr = bus_req & i_wb_we;
  wire bus_rd = bus_req & ~i_wb_we;
  wire [15:0] wmask = {{8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
  wire [15:0] wdat = i_wb_dat[15:0];

  wire sel_c3 = hit(i_wb_adr, `FLD_IDX_CTRL3);
  wire sel_xc = hit(i_wb_adr, `FLD_IDX_XCTL);
  wire sel_xd = hit(i_wb_adr, `FLD_IDX_XDATA);
  wire sel_ds = hit(i_wb_adr, `FLD_IDX_DSTAT);
  wire sel_is = hit(i_wb_adr, `FLD_IDX_IRQST);
  wire sel_im = hit(i_wb_adr, `FLD_IDX_IRQMSK);

  // Command and target decode
  wire fld_cmd_t cmd = fld_cmd_t'(xctl[`FLD_CMD_HI:`FLD_CMD_LO]);
  wire [4:0] dev = xctl[`FLD_DEV_HI:0];
  wire dev_ok = (dev == `FLD_DEV_VEND) | (dev == `FLD_DEV_M3) |
                (dev == `FLD_DEV_M7);
  // Data access reaches the target only for a valid device code
  wire xd_data = (cmd != FLD_CMD_ADDR) & dev_ok;
  wire xd_wr = bus_wr & sel_xd;
  wire xd_rd = bus_rd & sel_xd;
  // Pointer step after a data access
  wire inc_rw = (cmd == FLD_CMD_INC_RW) & (xd_wr | xd_rd);
  wire inc_w = (cmd == FLD_CMD_INC_W) & xd_wr;
  wire ptr_step = xd_data & (inc_rw | inc_w);

  // Criteria evaluation
  wire win_end = (win_cnt == WIN_LAST);
  wire [4:0] crit_en = {ctrl3[`FLD_B_DSCR], ctrl3[3:0]};
  wire hit_rx = i_rx_err & (cnt_rx == `FLD_THR_RXER - 6'h01);
  wire hit_ml = i_mlt3_err & (cnt_ml == `FLD_THR_MLT3 - 6'h01);
  wire hit_sn = i_snr_low & (cnt_sn == `FLD_THR_SNR - 6'h01);
  wire [4:0] cause;
  assign cause[CE] = i_energy_lost;
  assign cause[CS] = hit_sn;
  assign cause[CM] = hit_ml;
  assign cause[CR] = hit_rx;
  assign cause[CD] = i_dscr_lost;
  wire [4:0] drops = cause & crit_en;
  wire any_drop = |drops;

  // Read mux: unmapped addresses read zero
  wire [15:0] xd_rval = xd_data ? i_ext_rdata :
                        (cmd == FLD_CMD_ADDR ? xptr : 16'h0000);
  wire [15:0] rd_val =
      ({16{sel_c3}} & ctrl3) |
      ({16{sel_xc}} & (xctl & `FLD_XCTL_WMASK)) |
      ({16{sel_xd}} & xd_rval) |
      ({16{sel_ds}} & {7'h00, drop_stat, 4'h0}) |
      ({16{sel_is}} & {11'h000, irq_stat}) |
      ({16{sel_im}} & {11'h000, irq_mask});

  // Window counter and per-window event counters
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      win_cnt <= 11'h000;
    end else if (i_ce) begin
      win_cnt <= win_end ? 11'h000 : win_cnt + 11'h001;
    end
  end

  // Counters saturate at threshold and restart each window
  generate
    for (genvar g = 0; g < 3; g++) begin : g_cnt
      logic ev;
      logic [5:0] thr;
      logic [5:0] cnt;
      assign ev = (g == 0) ? i_rx_err : (g == 1) ? i_mlt3_err : i_snr_low;
      assign thr = (g == 0) ? `FLD_THR_RXER :
                   (g == 1) ? `FLD_THR_MLT3 : `FLD_THR_SNR;
      always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
          cnt <= 6'h00;
        end else if (i_ce) begin
          if (win_end) begin
            cnt <= 6'h00;
          end else if (ev && cnt != thr) begin
            cnt <= cnt + 6'h01;
          end
        end
      end
    end
  endgenerate
  assign cnt_rx = g_cnt[0].cnt;
  assign cnt_ml = g_cnt[1].cnt;
  assign cnt_sn = g_cnt[2].cnt;

  // Control registers, written with byte lanes
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl3 <= `FLD_CTRL3_RST;
      xctl <= 16'h0000;
      irq_mask <= 5'h00;
    end else if (i_ce && bus_wr) begin
      if (sel_c3) begin
        ctrl3 <= (ctrl3 & ~wmask) | (wdat & wmask);
      end
      if (sel_xc) begin
        xctl <= (xctl & ~wmask) | (wdat & wmask & `FLD_XCTL_WMASK);
      end
      if (sel_im && i_wb_sel[0]) begin
        irq_mask <= wdat[4:0];
      end
    end
  end

  // Address pointer, valid device codes only: loaded in address mode, stepped after FLD_CMD_INC_RW accesses and FLD_CMD_INC_W writes
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      xptr <= `FLD_XDATA_RST;
    end else if (i_ce) begin
      if (xd_wr && cmd == FLD_CMD_ADDR && dev_ok) begin
        xptr <= (xptr & ~wmask) | (wdat & wmask);
      end else if (ptr_step) begin
        xptr <= xptr + 16'h0001;
      end
    end
  end

  // Drop status latches; a read clears, a new cause in that cycle wins
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      drop_stat <= 5'h00;
    end else if (i_ce) begin
      drop_stat <= ((bus_rd && sel_ds) ? 5'h00 : drop_stat) | drops;
    end
  end

  // Sticky interrupt status, write one to clear, set wins
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_stat <= 5'h00;
    end else if (i_ce) begin
      irq_stat <= (irq_stat &
                  ~((bus_wr && sel_is && i_wb_sel[0]) ? wdat[4:0] : 5'h00))
                  | drops;
    end
  end

  // Bus answer: ack one cycle after the request
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else if (i_ce) begin
      o_wb_ack <= bus_req;
      o_wb_dat <= bus_rd ? {16'h0000, rd_val} : 32'h0000_0000;
    end
  end

  // Datapath steering and indirect request, all registered
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_path <= '0;
      o_link_drop <= 1'b0;
      o_ext_req <= '0;
      o_ext_stb <= 1'b0;
      o_irq <= 1'b0;
    end else if (i_ce) begin
      o_path.eq_tap0_bypass <= ctrl3[`FLD_B_EQBYP];
      o_path.pol_invert <= ctrl3[`FLD_B_POL];
      o_path.pair_swap <= ctrl3[`FLD_B_SWAP];
      o_path.mirror <= ctrl3[`FLD_B_POL] & ctrl3[`FLD_B_SWAP];
      o_link_drop <= any_drop;
      o_ext_stb <= xd_data & (xd_wr | xd_rd);
      o_ext_req.we <= xd_wr;
      o_ext_req.dev <= dev;
      o_ext_req.addr <= xptr;
      o_ext_req.wdata <= wdat;
      o_irq <= |(((irq_stat | drops)) & irq_mask);
    end
  end

endmodule

// File: pkg/fld_regs.svh
// Register offsets, field positions, reset values and timing counts for
// the link-drop and pair control block.
// Assumes a 200 MHz core clock and word-addressed Wishbone registers.
// Notes on behaviour
// - Bypass bit skips equalizer tap zero
// - Polarity bit inverts transmit and receive pairs
// - Pair swap exchanges transmit and receive pairs
// - Mirroring only when polarity and swap set
// - 32 receive errors per window drop link
// - 20 line-code violations per window drop link
// - 20 low-SNR crossings per window drop link
// - Energy loss drops link when enabled
// - Drop decision ORs five enabled criteria
// - Command field selects data register meaning
// - Descrambler loss drops link when enabled
// - Data register holds pointer or target data
// - Only three target device codes accepted
// - Per-criterion status latches on each drop
`ifndef FLD_REGS_SVH
`define FLD_REGS_SVH

// Register word indices (byte address is index times four)
`define FLD_IDX_CTRL3 8'h0b
`define FLD_IDX_XCTL 8'h0d
`define FLD_IDX_XDATA 8'h0e
`define FLD_IDX_DSTAT 8'h0f
`define FLD_IDX_IRQST 8'h20
`define FLD_IDX_IRQMSK 8'h21
`define FLD_ADDR_W 10

// Control three fields
`define FLD_B_DSCR 10
`define FLD_B_EQBYP 9
`define FLD_B_POL 6
`define FLD_B_SWAP 5
`define FLD_CTRL3_RST 16'h1000
`define FLD_CTRL3_WMASK 16'hffff

// Extended access control fields
`define FLD_CMD_HI 15
`define FLD_CMD_LO 14
`define FLD_DEV_HI 4
`define FLD_XCTL_WMASK 16'hc01f
`define FLD_DEV_VEND 5'h1f
`define FLD_DEV_M3 5'h03
`define FLD_DEV_M7 5'h07
`define FLD_XDATA_RST 16'h000a

// Status field position in the drop status register
`define FLD_STAT_LO 4

// Thresholds and window
`define FLD_THR_RXER 6'h20
`define FLD_THR_MLT3 6'h14
`define FLD_THR_SNR 6'h14
`define FLD_WIN_NS 10000
`define FLD_CLK_MHZ 200
`define FLD_WIN_CYC ((`FLD_WIN_NS * `FLD_CLK_MHZ) / 1000)

`endif

// File: pkg/fld_pkg.sv
// Types shared by the link-drop and pair control block.
// Assumes the constants header is compiled alongside.
package fld_pkg;

  // Extended access commands
  typedef enum logic [1:0] {
    FLD_CMD_ADDR = 2'b00,
    FLD_CMD_DATA = 2'b01,
    FLD_CMD_INC_RW = 2'b10,
    FLD_CMD_INC_W = 2'b11
  } fld_cmd_t;

  // Drop event vector: dscr, rxer, mlt3, snr, energy (bit 4 down to 0)
  typedef logic [4:0] fld_crit_t;

  // Datapath control outputs
  typedef struct packed {
    logic eq_tap0_bypass;
    logic pol_invert;
    logic pair_swap;
    logic mirror;
  } fld_path_t;

  // Indirect access request to the extended register space
  typedef struct packed {
    logic we;
    logic [4:0] dev;
    logic [15:0] addr;
    logic [15:0] wdata;
  } fld_ext_req_t;

endpackage

// File: verif/fld_ctrl_monitor.sv
// Checker on the link-drop block ports, bound below.
// Assumes control writes drive both low byte lanes.
`timescale 1ns/100ps
module fld_ctrl_monitor (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [9:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  input wire logic i_energy_lost,
  input wire logic i_dscr_lost,
  input wire fld_pkg::fld_path_t o_path,
  input wire logic o_link_drop,
  input wire fld_pkg::fld_ext_req_t o_ext_req,
  input wire logic o_ext_stb
);
  import fld_pkg::*;
  logic [15:0] sh; // Shadow of control three
  wire logic take = i_ce && i_wb_cyc && i_wb_stb && !o_wb_ack;
  // Shadow moves on the taken edge, as the register does
  always_ff @(posedge i_ref_clk or posedge i_rst)
    if (i_rst) sh <= 16'h1000;
    else if (take && i_wb_we && i_wb_adr == 10'h02c) sh <= i_wb_dat[15:0];
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  ack_pulse_a: assert property (o_wb_ack && i_ce |=> !o_wb_ack)
    else $error("ack too long");
  ack_next_a: assert property (take |=> o_wb_ack)
    else $error("no answer");
  idle_data_a: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
    else $error("data outside ack");
  path_bits_a: assert property (
    $past(sh) == sh |-> o_path[3:1] == {sh[9], sh[6], sh[5]})
    else $error("path bits wrong");
  mirror_pair_a: assert property (
    o_path.mirror == (o_path.pol_invert && o_path.pair_swap))
    else $error("mirror wrong");
  energy_drop_a: assert property (
    i_ce && i_energy_lost && sh[0] |=> o_link_drop)
    else $error("no energy drop");
  dscr_drop_a: assert property (
    i_ce && i_dscr_lost && sh[10] |=> o_link_drop)
    else $error("no dscr drop");
  no_cause_a: assert property (
    i_ce && !(i_energy_lost && sh[0]) && !(i_dscr_lost && sh[10])
    && sh[3:1] == 3'h0 |=> !o_link_drop)
    else $error("drop without cause");
  ext_dev_a: assert property (
    o_ext_stb |-> o_ext_req.dev inside {5'h1f, 5'h03, 5'h07})
    else $error("foreign device");
  drop_c: cover property (o_link_drop);
  ext_c: cover property (o_ext_stb);
  mirror_c: cover property (o_path.mirror);
endmodule
bind fld_ctrl fld_ctrl_monitor i_fld_ctrl_monitor (.i_ref_clk(i_ref_clk),
  .i_rst(i_rst), .i_ce(i_ce), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
  .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_dat(i_wb_dat),
  .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_energy_lost(i_energy_lost),
  .i_dscr_lost(i_dscr_lost), .o_path(o_path), .o_link_drop(o_link_drop),
  .o_ext_req(o_ext_req), .o_ext_stb(o_ext_stb));

// File: verif/fld_ctrl_bench.sv
// Bench for the link-drop block, one task per scenario.
// Assumes one-cycle bus answers and a 2000-cycle drop window.
`timescale 1ns/100ps
module fld_ctrl_bench;
  import fld_pkg::*;
  logic clk = 0;
  logic rst = 1;
  logic cyc = 0;
  logic we = 0;
  logic [9:0] adr = 0;
  logic [31:0] wd = 0;
  logic [31:0] rd; // Last read data
  logic [4:0] ev = 0; // Dscr, rx, mlt3, snr, energy
  logic [31:0] dat;
  logic ack, drop, stb, irq;
  fld_path_t path;
  fld_ext_req_t req, last;
  int n_errors = 0, checks_done = 0, cn = 0, nd = 0, ns = 0;
  always #2.5 clk = ~clk;
  fld_ctrl i_fld_ctrl (.i_ref_clk(clk), .i_rst(rst), .i_ce(1'b1),
    .i_wb_cyc(cyc), .i_wb_stb(cyc), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(4'hf), .i_wb_dat(wd), .o_wb_dat(dat), .o_wb_ack(ack),
    .i_rx_err(ev[3]), .i_mlt3_err(ev[2]), .i_snr_low(ev[1]),
    .i_energy_lost(ev[0]), .i_dscr_lost(ev[4]), .i_ext_rdata(16'h5a5a),
    .o_path(path), .o_link_drop(drop), .o_ext_req(req), .o_ext_stb(stb),
    .o_irq(irq));
  // Window phase, drop cycles and strobes
  always @(posedge clk) begin
    cn <= rst ? 0 : cn + 1;
    nd <= nd + (drop === 1'b1);
    if (stb === 1'b1) begin
      ns <= ns + 1;
      last <= req;
    end
  end
  task automatic test_done;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  // Bounded wait; running out ends the run
  task automatic bound(input int k, input int lim);
    if (k >= lim) begin
      chk(0, 1);
      test_done();
    end
  endtask
  // Classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [9:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    cyc <= 1;
    we <= w;
    adr <= a;
    wd <= d;
    // Ack and data are looked at mid-cycle, where they have settled
    for (k = 0; k < 20; k++) begin
      @(negedge clk);
      if (ack === 1'b1) break;
    end
    bound(k, 20);
    rd = dat;
    // Release only after the edge at which ack is sampled high
    @(posedge clk);
    cyc <= 0;
    we <= 0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // n back-to-back high cycles on event line k
  task automatic burst(input int k, input int n);
    @(posedge clk) ev[k] <= 1'b1;
    repeat (n - 1) @(posedge clk);
    @(posedge clk) ev[k] <= 1'b0;
  endtask
  task automatic align(input int m);
    int k;
    for (k = 0; k < 4000 && cn % 2000 != m; k++) @(posedge clk);
    bound(k, 4000);
  endtask
  // Two sub-threshold bursts split by a window edge
  task automatic t_window;
    int b;
    wb(1, 10'h02c, 32'h1008);
    align(1950);
    b = nd;
    burst(3, 31);
    align(30);
    burst(3, 31);
    idle(3);
    chk(nd - b, 0);
    // Leave the window so later count scenarios start from zero
    align(0);
  endtask
  task automatic t_path;
    wb(1, 10'h02c, 32'h1260);
    idle(2);
    chk(path, 4'hf);
    wb(1, 10'h02c, 32'h1020);
    idle(2);
    chk(path, 4'h2);
  endtask
  // One short of the threshold, then the deciding event
  task automatic t_count(input int k, input int thr);
    int b;
    wb(1, 10'h02c, 32'h1000 | (1 << k));
    wb(0, 10'h03c, 0);
    align(500);
    b = nd;
    burst(k, thr - 1);
    idle(3);
    chk(nd - b, 0);
    burst(k, 1);
    idle(3);
    chk(nd - b > 0, 1);
    wb(0, 10'h03c, 0);
    chk(rd, 32'h10 << k);
  endtask
  // Level causes, with descrambler loss first disabled
  task automatic t_level(input int k, input logic [31:0] c, input logic e);
    int b;
    wb(1, 10'h02c, c);
    b = nd;
    burst(k, 3);
    idle(2);
    chk(nd - b > 0, e);
  endtask
  task automatic t_ext;
    wb(1, 10'h034, 32'h001f);
    wb(0, 10'h038, 0);
    chk(rd, 32'h000a);
    wb(1, 10'h038, 32'h0100);
    wb(1, 10'h034, 32'h801f);
    wb(1, 10'h038, 32'h1234);
    idle(2);
    chk(last, {1'b1, 5'h1f, 16'h0100, 16'h1234});
    wb(0, 10'h038, 0);
    idle(2);
    chk({rd[15:0], last.addr}, 32'h5a5a0101);
    wb(1, 10'h034, 32'hc01f);
    wb(0, 10'h038, 0);
    wb(0, 10'h038, 0);
    wb(1, 10'h034, 32'h401f);
    wb(1, 10'h038, 0);
    idle(2);
    chk(last.addr, 16'h0102);
    wb(1, 10'h034, 32'h4002);
    wb(0, 10'h038, 0);
    idle(2);
    chk({rd[15:0], ns[15:0]}, {16'h0000, 16'd5});
  endtask
  task automatic t_irq;
    wb(0, 10'h080, 0);
    chk({rd, irq}, 33'h3e);
    wb(1, 10'h084, 32'h1f);
    idle(2);
    chk(irq, 1);
    wb(1, 10'h080, 32'h1f);
    idle(2);
    chk(irq, 0);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 0;
    wb(0, 10'h02c, 0);
    chk(rd, 32'h1000);
    wb(0, 10'h100, 0);
    chk(rd, 0);
    t_window;
    t_path;
    t_count(3, 32);
    t_count(2, 20);
    t_count(1, 20);
    t_level(0, 32'h1001, 1);
    t_level(4, 32'h1000, 0);
    t_level(4, 32'h1400, 1);
    t_ext;
    t_irq;
    test_done;
  end
endmodule
